// ### pkg/emw_regs.vh
// Operation
// [RL1] Four separate copies per security space; the code keeps one copy of each register per space, four sets in all.
// [RL2] Each copy reachable only via own frame.
// [RL3] Attribute register decoded at offset 0xec.
// [RL4] Payload register decoded at offset 0xe8.
// [RL5] Root and Realm writable only with realm extension.
// [RL6] Without capability flag, locations read zero.
// [RL7] Full 32-bit payload word sent in write.
// [RL8] Payload taken from erroring space's copy.
// [RL9] Monitor group in [23:16]; [31:24] read zero.
// [RL10] Partition label held in bits [15:0].
// [RL11] Partition label interpreted in its own space.
// [RL12] Labels not reset; software programs first.
// [RL13] Labels come only from own space's copy.
// [RL14] Enable bit 0 gates writes, suppresses wire.
// [RL15] Address bits [31:2] kept, [1:0] read zero.
// [RL16] Reserved device types map to strictest; shareability ignored.
// [RL17] One write per enabled error, all attributes; the code drops an error while a write waits for WR_READY.
`ifndef EMW_REGS_VH
`define EMW_REGS_VH
`define EMW_OFS_ADDR_LOW 12'h0e0
`define EMW_OFS_LABELS 12'h0dc
`define EMW_OFS_PAYLOAD 12'h0e8
`define EMW_OFS_ATTR 12'h0ec
`define EMW_ATTR_EN_BIT 0
`define EMW_ATTR_EN_RESET 1'b0
`define EMW_LABEL_PART_HI 15
`define EMW_LABEL_PART_LO 0
`define EMW_LABEL_GROUP_HI 23
`define EMW_LABEL_GROUP_LO 16
`define EMW_ATTR_MEMTYPE_HI 27
`define EMW_ATTR_MEMTYPE_LO 24
`define EMW_ATTR_SH_HI 29
`define EMW_ATTR_SH_LO 28
`define EMW_ATTR_MASK 32'h3f000001
`define EMW_LABELS_MASK 32'h00ffffff
`define EMW_ADDR_MASK 32'hfffffffc
`define EMW_SH_OUTER 2'h2
`define EMW_SPACE_SECURE 2'h0
`define EMW_SPACE_NONSECURE 2'h1
`define EMW_SPACE_ROOT 2'h2
`define EMW_SPACE_REALM 2'h3
`endif

// ### core/emw_error_msg_regs.v
`timescale 1ns/100ps
`include "emw_regs.vh"
module emw_error_msg_regs #(
	parameter MSG_SUPPORTED = 1'b1,
	parameter REALM_FEATURE = 1'b1
) (
	input wire CORE_CLK,
	input wire RST,
	input wire CLK_EN,
	input wire REG_SEL,
	input wire REG_WR,
	input wire [1:0] REG_SPACE,
	input wire [11:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	output reg [31:0] REG_RDATA,
	input wire ERR_EVENT,
	input wire [1:0] ERR_SPACE,
	output reg WR_VALID,
	input wire WR_READY,
	output reg [1:0] WR_SPACE,
	output reg [31:0] WR_ADDR,
	output reg [31:0] WR_DATA,
	output reg [3:0] WR_MEMTYPE,
	output reg [1:0] WR_SHARE,
	output reg [15:0] WR_PARTITION,
	output reg [7:0] WR_MONGROUP,
	output reg WIRED_IRQ
);
	// Number of security spaces; each owns a private copy of every register.
	localparam SPACES = 4;

	// Request terms after the clock enable; a low enable freezes every register.
	wire access_go;
	wire write_go;
	wire error_go;

	// Space code widened so that it compares cleanly with the loop index.
	wire [31:0] reg_space_wide;

	// High when the frame of the current access may see the registers at all.
	reg space_ok;

	// Read data for the next registered answer.
	reg [31:0] next_rdata;

	// All copies of each register, one 32-bit slice per space.
	wire [32*SPACES-1:0] addr_low_all;
	wire [32*SPACES-1:0] payload_all;
	wire [32*SPACES-1:0] attr_all;
	wire [32*SPACES-1:0] labels_all;

	// Copies that belong to the space whose error is being reported.
	reg [31:0] err_addr;
	reg [31:0] err_payload;
	reg [31:0] err_attr;
	reg [31:0] err_labels;

	// Memory type after the reserved encodings fold onto the strictest type.
	reg [3:0] mt;

	// Shareability carried by the write.
	reg [1:0] share;

	// High when the erroring space has message writes switched on.
	wire msg_on;

	// High when the write channel can take a new message in this cycle.
	wire slot_free;

	genvar g;

	// Accesses and errors are only taken on cycles with the clock enable high.
	assign access_go = CLK_EN && REG_SEL;
	assign write_go = access_go && REG_WR && space_ok;
	assign error_go = CLK_EN && ERR_EVENT;
	assign reg_space_wide = {30'h0, REG_SPACE};

	// Root and Realm frames only exist with the realm extension, and no frame
	// sees anything without the capability flag; refused frames read zero.
	always @* begin
		space_ok = 1'b0;
		if (MSG_SUPPORTED != 0) begin // RL6
			if (REG_SPACE == `EMW_SPACE_SECURE || REG_SPACE == `EMW_SPACE_NONSECURE) begin
				space_ok = 1'b1; // RL5
			end else begin
				space_ok = (REALM_FEATURE != 0); // RL5
			end
		end
	end

	// One set of copies per space; nothing is shared between the sets.
	generate
		for (g = 0; g < SPACES; g = g + 1) begin : space_copy
			// Stored values of this space's copies.
			reg [31:0] addr_low;
			reg [31:0] payload;
			reg [31:0] attr;
			reg [31:0] labels;

			// High when the current write arrived on this space's own frame.
			wire own_write;

			assign own_write = write_go && (reg_space_wide == g); // RL1 RL2

			// Only the enable bit has a reset value, so a reset never leaves a
			// half-programmed space sending writes; the rest waits for software.
			always @(posedge CORE_CLK) begin
				if (RST) begin
					attr[`EMW_ATTR_EN_BIT] <= `EMW_ATTR_EN_RESET; // RL14
				end else if (own_write) begin
					case (REG_ADDR)
						`EMW_OFS_ADDR_LOW: begin
							addr_low <= REG_WDATA & `EMW_ADDR_MASK; // RL15
						end
						`EMW_OFS_PAYLOAD: begin
							payload <= REG_WDATA; // RL4 RL7
						end
						`EMW_OFS_ATTR: begin
							attr <= REG_WDATA & `EMW_ATTR_MASK; // RL3
						end
						`EMW_OFS_LABELS: begin
							labels <= REG_WDATA & `EMW_LABELS_MASK; // RL9 RL12
						end
						default: begin
						end
					endcase
				end
			end

			// Reserved bits are masked again on the way out, because storage that was
			// never written still holds unknown bits there.
			assign addr_low_all[32*g +: 32] = addr_low & `EMW_ADDR_MASK; // RL15
			assign payload_all[32*g +: 32] = payload;
			assign attr_all[32*g +: 32] = attr & `EMW_ATTR_MASK;
			assign labels_all[32*g +: 32] = labels & `EMW_LABELS_MASK; // RL9
		end
	endgenerate

	// The frame a request arrives on selects the copy, so no space reaches another's.
	always @* begin
		next_rdata = 32'h00000000;
		if (space_ok) begin
			case (REG_ADDR)
				`EMW_OFS_ADDR_LOW: begin
					next_rdata = addr_low_all[{REG_SPACE, 5'h00} +: 32]; // RL2 RL15
				end
				`EMW_OFS_PAYLOAD: begin
					next_rdata = payload_all[{REG_SPACE, 5'h00} +: 32]; // RL2 RL4 RL7
				end
				`EMW_OFS_ATTR: begin
					next_rdata = attr_all[{REG_SPACE, 5'h00} +: 32]; // RL2 RL3
				end
				`EMW_OFS_LABELS: begin
					next_rdata = labels_all[{REG_SPACE, 5'h00} +: 32]; // RL9 RL10
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// Registered read answer; it stands until the next access is taken.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			REG_RDATA <= 32'h00000000;
		end else if (access_go) begin
			REG_RDATA <= next_rdata;
		end
	end

	// Copies that the erroring space's write is built from.
	always @* begin
		err_addr = addr_low_all[{ERR_SPACE, 5'h00} +: 32]; // RL15
		err_payload = payload_all[{ERR_SPACE, 5'h00} +: 32]; // RL8
		err_attr = attr_all[{ERR_SPACE, 5'h00} +: 32]; // RL14
		err_labels = labels_all[{ERR_SPACE, 5'h00} +: 32]; // RL13
	end

	// Without the capability flag no message is ever sent, whatever was stored.
	assign msg_on = (MSG_SUPPORTED != 0) && err_attr[`EMW_ATTR_EN_BIT]; // RL6 RL14
	assign slot_free = !WR_VALID || WR_READY;

	// Reserved device encodings become the strictest type, and every device type
	// is sent as outer shareable whatever the shareability field holds.
	always @* begin
		mt = err_attr[`EMW_ATTR_MEMTYPE_HI:`EMW_ATTR_MEMTYPE_LO];
		if (mt[1:0] == 2'h0) begin
			mt = 4'h0; // RL16
		end
		share = err_attr[`EMW_ATTR_SH_HI:`EMW_ATTR_SH_LO];
		if (mt[3:2] == 2'h0) begin
			share = `EMW_SH_OUTER; // RL16
		end
	end

	// The wired interrupt pulses only for errors whose space has messages off.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			WIRED_IRQ <= 1'b0;
		end else if (CLK_EN) begin
			WIRED_IRQ <= error_go && !msg_on; // RL14
		end
	end

	// One write per enabled error; a new error is dropped while a write is pending,
	// which keeps the fields steady under a stalled receiver at the cost of a message.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			WR_VALID <= 1'b0;
			WR_SPACE <= 2'h0;
			WR_ADDR <= 32'h00000000;
			WR_DATA <= 32'h00000000;
			WR_MEMTYPE <= 4'h0;
			WR_SHARE <= 2'h0;
			WR_PARTITION <= 16'h0000;
			WR_MONGROUP <= 8'h00;
		end else if (CLK_EN) begin
			if (WR_VALID && WR_READY) begin
				WR_VALID <= 1'b0;
			end
			if (error_go && msg_on && slot_free) begin
				WR_VALID <= 1'b1; // RL14 RL17
				WR_SPACE <= ERR_SPACE; // RL11
				WR_ADDR <= err_addr; // RL15 RL17
				WR_DATA <= err_payload; // RL7 RL8
				WR_MEMTYPE <= mt; // RL16
				WR_SHARE <= share; // RL16
				WR_PARTITION <= err_labels[`EMW_LABEL_PART_HI:`EMW_LABEL_PART_LO]; // RL10 RL13
				WR_MONGROUP <= err_labels[`EMW_LABEL_GROUP_HI:`EMW_LABEL_GROUP_LO]; // RL9 RL13
			end
		end
	end
endmodule // emw_error_msg_regs

// ### dv/emw_monitor.sv
`timescale 1ns/100ps
module emw_monitor(input wire CORE_CLK, input wire RST, input wire CLK_EN,
	input wire ERR_EVENT, input wire WR_READY, input wire WR_VALID, input wire WIRED_IRQ,
	input wire [3:0] WR_MEMTYPE, input wire [1:0] WR_SHARE);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// A write that is standing but not yet taken must not change under the receiver.
	sequence s_wait; WR_VALID && !WR_READY; endsequence
	sequence s_taken; WR_VALID && WR_READY && CLK_EN && !ERR_EVENT; endsequence
	a_write_holds: assert property (s_wait |=> WR_VALID) else $error("write dropped");
	a_attr_stable: assert property (s_wait |=> $stable(WR_MEMTYPE))
		else $error("type moved");
	a_write_ends: assert property (s_taken |=> !WR_VALID) else $error("write stuck");
	a_write_cause: assert property ($rose(WR_VALID) |-> $past(ERR_EVENT))
		else $error("write uncaused");
	a_irq_cause: assert property (WIRED_IRQ && $past(CLK_EN) |-> $past(ERR_EVENT))
		else $error("irq uncaused");
	a_irq_excl: assert property (!(WIRED_IRQ && $rose(WR_VALID))) else $error("both");
	a_no_resv: assert property (WR_VALID |-> !(WR_MEMTYPE[1:0] == 2'h0 &&
		WR_MEMTYPE[3:2] != 2'h0)) else $error("reserved type");
	a_dev_share: assert property (WR_VALID && WR_MEMTYPE[3:2] == 2'h0 |-> WR_SHARE == 2'h2)
		else $error("device share");
endmodule // emw_monitor
bind emw_error_msg_regs emw_monitor emw_monitor_i(.CORE_CLK, .RST, .CLK_EN, .ERR_EVENT,
	.WR_READY, .WR_VALID, .WIRED_IRQ, .WR_MEMTYPE, .WR_SHARE);

// ### dv/emw_its_model.sv
`timescale 1ns/100ps
module emw_its_model #(parameter STALL = 3) (input wire CORE_CLK, input wire WR_VALID,
	input wire [31:0] WR_DATA, output reg WR_READY, output reg [31:0] got);
	integer w = 0;
	initial WR_READY = 0;
	// Stalling makes the block keep its write standing for several cycles.
	always @(posedge CORE_CLK) begin
		WR_READY <= WR_VALID && !WR_READY && w >= STALL;
		w <= (WR_VALID && !WR_READY) ? w + 1 : 0;
		if (WR_VALID && WR_READY) got <= WR_DATA;
	end
endmodule // emw_its_model

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", n, e, v); end end
	reg CORE_CLK = 0, RST = 1, REG_SEL = 0, REG_WR = 0, ERR_EVENT = 0, CLK_EN = 1;
	reg [1:0] REG_SPACE = 0, ERR_SPACE = 0;
	reg [11:0] REG_ADDR = 0;
	reg [31:0] REG_WDATA = 0;
	wire [31:0] REG_RDATA, WR_ADDR, WR_DATA, got;
	wire [15:0] WR_PARTITION;
	wire [7:0] WR_MONGROUP;
	wire [3:0] WR_MEMTYPE;
	wire [1:0] WR_SPACE, WR_SHARE;
	wire WR_VALID, WR_READY, WIRED_IRQ;
	integer n_fail = 0, check_count = 0, i;
	// Rows: space, offset, readable mask; data written is a per-row pattern.
	reg [45:0] row [0:7] = '{{2'h0, 12'h0e8, 32'hffffffff}, {2'h1, 12'h0e8, 32'hffffffff},
		{2'h2, 12'h0e8, 32'hffffffff}, {2'h3, 12'h0e8, 32'hffffffff},
		{2'h1, 12'h0ec, 32'h3f000001}, {2'h2, 12'h0dc, 32'h00ffffff},
		{2'h3, 12'h0e0, 32'hfffffffc}, {2'h0, 12'h0f0, 32'h00000000}};
	always #10 CORE_CLK = ~CORE_CLK;
	emw_error_msg_regs emw_error_msg_regs_i(.CORE_CLK, .RST, .CLK_EN, .REG_SEL, .REG_WR,
		.REG_SPACE, .REG_ADDR, .REG_WDATA, .REG_RDATA, .ERR_EVENT, .ERR_SPACE, .WR_VALID,
		.WR_READY, .WR_SPACE, .WR_ADDR, .WR_DATA, .WR_MEMTYPE, .WR_SHARE, .WR_PARTITION,
		.WR_MONGROUP, .WIRED_IRQ);
	emw_its_model emw_its_model_i(.CORE_CLK, .WR_VALID, .WR_DATA, .WR_READY, .got);
	task acc(input [1:0] s, input [11:0] a, input w, input [31:0] d); begin
		REG_SEL = 1; REG_WR = w; REG_SPACE = s; REG_ADDR = a; REG_WDATA = d;
		@(negedge CORE_CLK); REG_SEL = 0; @(negedge CORE_CLK); end
	endtask
	task err(input [1:0] s); begin
		ERR_EVENT = 1; ERR_SPACE = s; @(negedge CORE_CLK); ERR_EVENT = 0; end
	endtask
	task results; begin
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish; end
	endtask
	// Main sequence; the limit below cuts a hang short.
	initial begin
		repeat (4) @(negedge CORE_CLK);
		RST = 0;
		for (i = 0; i < 8; i++) acc(row[i][45:44], row[i][43:32], 1, 32'h11111111 * (i + 1));
		for (i = 0; i < 8; i++) begin
			acc(row[i][45:44], row[i][43:32], 0, 0);
			`CHK("rd", (32'h11111111 * (i + 1)) & row[i][31:0], REG_RDATA)
		end
		$display("registers done");
		acc(1, 12'h0dc, 1, 32'h00ab1234); acc(1, 12'h0ec, 1, 32'h04000001);
		acc(1, 12'h0e0, 1, 32'h12345677);
		err(1);
		`CHK("dat", 32'h22222222, WR_DATA)
		`CHK("lbl", 24'hab1234, {WR_MONGROUP, WR_PARTITION})
		`CHK("type", 6'h02, {WR_MEMTYPE, WR_SHARE})
		`CHK("adr", 32'h12345674, WR_ADDR)
		`CHK("spc", 2'h1, WR_SPACE)
		`CHK("nowire", 1'b0, WIRED_IRQ)
		repeat (8) @(negedge CORE_CLK);
		`CHK("its", 32'h22222222, got)
		err(0);
		`CHK("irq", 2'h1, {WR_VALID, WIRED_IRQ})
		$display("errors done");
		// A low clock enable must swallow both a register write and an error.
		@(negedge CORE_CLK);
		CLK_EN = 0;
		acc(0, 12'h0e8, 1, 32'h99999999);
		err(0);
		`CHK("frz", 1'b0, WIRED_IRQ)
		CLK_EN = 1;
		acc(0, 12'h0e8, 0, 32'h00000000);
		`CHK("keep", 32'h11111111, REG_RDATA)
		$display("freeze done");
		// A reset in mid-run clears only the enable bit; the message turns into a wire.
		RST = 1;
		@(negedge CORE_CLK);
		RST = 0;
		acc(1, 12'h0ec, 0, 32'h00000000);
		`CHK("rst", 32'h04000000, REG_RDATA)
		err(1);
		`CHK("off", 2'h1, {WR_VALID, WIRED_IRQ})
		$display("reset done");
		results;
	end
	initial begin #20000; n_fail++; results; end
endmodule // testbench
